// [floppy_host_status_data_regs.sv]
// host status, data port and digital input registers with data fifo
//
// Operation
// - status register readable any time at 0x04
// - status valid right after a data transfer
// - bits 0-3 show drives seeking
// - bit 4 set on first command byte
// - bit 4 clears after last byte without results
// - bit 5 marks polled execution phase
// - bit 6 gives transfer direction
// - bit 7 permits data port access
// - single data port at 0x05 gated by flags
// - fifo disabled after reset, enabled by configure
// - fifo inactive during command byte phase
// - fifo flushed on entering execution phase
// - late service aborts command and transfer
// - underrun fills sector with zero bytes
// - basic mode drives only bit 7
// - bit 7 is inverted disk change
// - extended mode shows density, rate, ones
// - rate kept on soft reset, 250k hardware
// - legacy mode mirrors dma enable, precomp
// - write-only rate control at 0x07
// - latest rate write from either register wins
`timescale 1ns/1ns
`default_nettype none

module fifo_buffer #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  input  wire logic                       clear,
  input  wire logic                       in_valid,
  input  wire logic [width-1:0]           in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [width-1:0]                out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(depth+1)-1:0]      count
);
  localparam int aw = $clog2(depth);
  localparam int cw = $clog2(depth+1);
  localparam logic [cw-1:0] full_count = cw'(depth);
  localparam logic [aw-1:0] last_index = aw'(depth - 1);

  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw-1:0]               wp;
    logic [aw-1:0]               rp;
    logic [cw-1:0]               cnt;
  } fifo_state_type;

  fifo_state_type s;
  fifo_state_type next_s;
  logic           push;
  logic           pop;

  assign in_ready  = s.cnt != full_count;
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rp];
  assign count     = s.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  function automatic logic [aw-1:0] wrap_inc(input logic [aw-1:0] p);
    wrap_inc = (p == last_index) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = wrap_inc(s.wp);
    end
    if (pop) begin
      next_s.rp = wrap_inc(s.rp);
    end
    next_s.cnt = s.cnt + cw'(push) - cw'(pop);
    if (clear) begin
      next_s.wp  = '0;
      next_s.rp  = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

module floppy_host_status_data_regs #(
  parameter int fifo_width = floppy_regs_pkg::data_width,
  parameter int fifo_words = floppy_regs_pkg::fifo_depth
) (
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            ce,
  input  wire floppy_regs_pkg::io_req_type     io,
  output logic [7:0]                           io_rdata,
  output logic [7:0]                           io_rdata_oe_n,
  input  wire floppy_regs_pkg::engine_ctl_type eng,
  input  wire logic                            eng_byte_valid,
  input  wire logic [7:0]                      eng_byte_data,
  output logic                                 eng_byte_ready,
  output logic                                 to_eng_valid,
  output logic [7:0]                           to_eng_data,
  input  wire logic                            eng_take,
  input  wire logic                            disk_change_pin,
  output logic                                 xfer_abort,
  output logic                                 zero_fill,
  output logic                                 service_due
);
  localparam int cw = $clog2(fifo_words + 1);
  localparam logic [cw-1:0] words_c = cw'(fifo_words);

  floppy_regs_pkg::front_state_type s;
  floppy_regs_pkg::front_state_type next_s;

  logic          in_exec;
  logic          dir;
  logic          fifo_mode;
  logic          req;
  logic          eng_ready_c;
  logic          host_data_rd;
  logic          host_data_wr;
  logic          host_pop;
  logic          host_push;
  logic          underrun;
  logic          overrun;
  logic          flush;
  logic          f_in_valid;
  logic [7:0]    f_in_data;
  logic          f_in_ready;
  logic          f_out_valid;
  logic [7:0]    f_out_data;
  logic          f_out_ready;
  logic [cw-1:0] f_count;
  logic          f_empty;
  logic [7:0]    status;
  logic [7:0]    dir_value;
  logic [7:0]    dir_oe_n;

  function automatic logic is_access(input logic strobe, input logic [2:0] addr,
                                     input logic [2:0] target);
    is_access = strobe & (addr == target);
  endfunction

  assign in_exec   = eng.phase == floppy_regs_pkg::phase_exec;
  assign dir       = (eng.phase == floppy_regs_pkg::phase_result)
                   | (in_exec & eng.exec_read);
  // fifo depth only applies once execution has started
  assign fifo_mode = eng.fifo_enable & in_exec;
  assign f_empty   = f_count == '0;
  // write side blocks after a fault; read side stays open so the host can drain
  assign req       = dir ? f_out_valid
                         : (!s.halted & (fifo_mode ? f_in_ready : f_empty));
  assign eng_ready_c = fifo_mode ? f_in_ready : f_empty;

  assign host_data_rd = is_access(io.rd, io.addr, floppy_regs_pkg::command_data_port_addr);
  assign host_data_wr = is_access(io.wr, io.addr, floppy_regs_pkg::command_data_port_addr);
  assign host_pop     = host_data_rd & req & dir;
  assign host_push    = host_data_wr & req & !dir;
  assign underrun     = in_exec & !dir & eng_take & f_empty & !s.halted;
  assign overrun      = in_exec & dir & eng_byte_valid & !eng_ready_c;
  assign flush        = eng.soft_reset | (in_exec & !s.exec_seen);

  assign f_in_valid  = dir ? (eng_byte_valid & eng_ready_c) : host_push;
  assign f_in_data   = dir ? eng_byte_data : io.wdata;
  assign f_out_ready = dir ? host_pop : (eng_take & !s.halted);

  fifo_buffer #(
    .width (fifo_width),
    .depth (fifo_words)
  ) data_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .clear     (flush),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready),
    .count     (f_count)
  );

  // engine-facing handshakes follow the fifo flags directly, except that halted forces to_eng_valid high while dir is low
  assign eng_byte_ready = dir & eng_ready_c;
  assign to_eng_valid   = !dir & (s.halted | f_out_valid);
  assign to_eng_data    = s.halted ? floppy_regs_pkg::underrun_fill : f_out_data;

  // status is built from live state, so a read right after a transfer is exact
  assign status = {req, dir, eng.polled_mode & in_exec, s.busy,
                   eng.drive_seeking_flag};

  always_comb begin
    dir_value = {!s.dchg_sync, 7'h00};
    dir_oe_n  = floppy_regs_pkg::basic_dir_oe_n;
    case (eng.reg_mode)
      floppy_regs_pkg::extended_compat_mode: begin
        dir_value = {!s.dchg_sync, floppy_regs_pkg::ext_ones, s.rate,
                     s.rate[1] ^ s.rate[0]};
        dir_oe_n  = floppy_regs_pkg::bus_drive_oe_n;
      end
      floppy_regs_pkg::legacy_model_mode: begin
        dir_value = {!s.dchg_sync, floppy_regs_pkg::legacy_zeros,
                     eng.dma_enable_mirror, s.no_precomp, s.rate};
        dir_oe_n  = floppy_regs_pkg::bus_drive_oe_n;
      end
      default: begin
        dir_value = {!s.dchg_sync, 7'h00};
        dir_oe_n  = floppy_regs_pkg::basic_dir_oe_n;
      end
    endcase
  end

  always_comb begin
    next_s            = s;
    next_s.dchg_meta  = disk_change_pin;
    next_s.dchg_sync  = s.dchg_meta;
    next_s.exec_seen  = in_exec;
    next_s.abort      = underrun | overrun;
    next_s.service_due = fifo_mode
                       & (dir ? (f_count >= cw'(eng.threshold))
                              : ((words_c - f_count) >= cw'(eng.threshold)));
    if (eng.cmd_end | eng.soft_reset) begin
      next_s.halted = 1'b0;
      next_s.busy   = 1'b0;
    end
    // a fault in the same cycle as the command end still lands
    if (underrun | overrun) begin
      next_s.halted = 1'b1;
    end
    if (host_push & (eng.phase == floppy_regs_pkg::phase_idle)) begin
      next_s.busy = 1'b1;
    end
    // soft reset leaves the rate alone; only nrst restores it
    if (eng.rate_select_wr) begin
      next_s.rate = eng.rate_select_in;
    end
    if (is_access(io.wr, io.addr, floppy_regs_pkg::digital_input_addr)) begin
      next_s.rate = io.wdata[1:0];
      if (eng.reg_mode == floppy_regs_pkg::legacy_model_mode) begin
        next_s.no_precomp = io.wdata[2];
      end
    end
    next_s.rdata      = 8'h00;
    next_s.rdata_oe_n = floppy_regs_pkg::bus_idle_oe_n;
    if (io.rd) begin
      case (io.addr)
        floppy_regs_pkg::main_status_addr: begin
          next_s.rdata      = status;
          next_s.rdata_oe_n = floppy_regs_pkg::bus_drive_oe_n;
        end
        floppy_regs_pkg::command_data_port_addr: begin
          next_s.rdata      = host_pop ? f_out_data : 8'h00;
          next_s.rdata_oe_n = floppy_regs_pkg::bus_drive_oe_n;
        end
        floppy_regs_pkg::digital_input_addr: begin
          next_s.rdata      = dir_value;
          next_s.rdata_oe_n = dir_oe_n;
        end
        default: begin
          next_s.rdata      = 8'h00;
          next_s.rdata_oe_n = floppy_regs_pkg::bus_idle_oe_n;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s            <= '0;
      s.rate       <= floppy_regs_pkg::rate_reset;
      s.rdata_oe_n <= floppy_regs_pkg::bus_idle_oe_n;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign io_rdata      = s.rdata;
  assign io_rdata_oe_n = s.rdata_oe_n;
  assign xfer_abort    = s.abort;
  assign zero_fill     = s.halted;
  assign service_due   = s.service_due;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_status_read: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::main_status_addr
    |=> io_rdata_oe_n == 8'h00 && io_rdata[7:6] == $past({req, dir}))
    else $error("status read not answered");

  chk_busy_set: assert property (
    ce & host_push & eng.phase == floppy_regs_pkg::phase_idle |=> s.busy)
    else $error("busy not set by first command byte");

  chk_busy_clear: assert property (
    ce & eng.cmd_end & !host_push |=> !s.busy)
    else $error("busy not cleared at command end");

  chk_rate_write: assert property (
    ce & io.wr & io.addr == floppy_regs_pkg::digital_input_addr
    |=> s.rate == $past(io.wdata[1:0]))
    else $error("rate control write lost");

  chk_exec_flush: assert property (
    ce & in_exec & !s.exec_seen |=> f_count == '0)
    else $error("fifo not flushed on execution entry");

  chk_basic_layout: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::digital_input_addr
    & eng.reg_mode == floppy_regs_pkg::basic_compat_mode
    |=> io_rdata_oe_n == 8'h7f)
    else $error("basic mode drives low bits");

  chk_disk_change: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::digital_input_addr
    |=> io_rdata[7] == !$past(s.dchg_sync))
    else $error("disk change bit not inverted");

  chk_underrun_fill: assert property (
    ce & underrun |=> zero_fill && xfer_abort && to_eng_data == 8'h00)
    else $error("underrun not zero filled");

  chk_seek_bits: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::main_status_addr
    |=> io_rdata[3:0] == $past(eng.drive_seeking_flag))
    else $error("seek bits not reported");

  chk_polled_bit: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::main_status_addr
    |=> io_rdata[5] == $past(eng.polled_mode & (eng.phase == floppy_regs_pkg::phase_exec)))
    else $error("polled bit wrong");

  chk_empty_read: assert property (
    ce & host_data_rd & !req |=> io_rdata == 8'h00 && io_rdata_oe_n == 8'h00)
    else $error("data read without request returned data");

  chk_overrun_abort: assert property (
    ce & overrun |=> xfer_abort && zero_fill)
    else $error("overrun did not abort");

  chk_soft_rate: assert property (
    ce & eng.soft_reset & !eng.rate_select_wr
    & !(io.wr & io.addr == floppy_regs_pkg::digital_input_addr)
    |=> s.rate == $past(s.rate))
    else $error("soft reset changed rate");

  chk_rate_select: assert property (
    ce & eng.rate_select_wr & !(io.wr & io.addr == floppy_regs_pkg::digital_input_addr)
    |=> s.rate == $past(eng.rate_select_in))
    else $error("rate select write lost");

  chk_ext_layout: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::digital_input_addr
    & eng.reg_mode == floppy_regs_pkg::extended_compat_mode
    |=> io_rdata[6:3] == 4'hf && io_rdata_oe_n == 8'h00)
    else $error("extended layout wrong");

  chk_legacy_layout: assert property (
    ce & io.rd & io.addr == floppy_regs_pkg::digital_input_addr
    & eng.reg_mode == floppy_regs_pkg::legacy_model_mode
    |=> io_rdata[6:4] == 3'h0 && io_rdata[3] == $past(eng.dma_enable_mirror))
    else $error("legacy layout wrong");
endmodule

`default_nettype wire

// [floppy_regs_pkg.sv]
// shared constants and types for the floppy host register front end
package floppy_regs_pkg;

  localparam logic [2:0] main_status_addr       = 3'h4;
  localparam logic [2:0] command_data_port_addr = 3'h5;
  localparam logic [2:0] digital_input_addr     = 3'h7;

  localparam int        data_width  = 8;
  localparam int        fifo_depth  = 16;
  localparam logic [1:0] rate_reset = 2'h2;
  localparam logic [7:0] bus_idle_oe_n   = 8'hff;
  localparam logic [7:0] basic_dir_oe_n  = 8'h7f;
  localparam logic [7:0] bus_drive_oe_n  = 8'h00;
  localparam logic [3:0] ext_ones        = 4'hf;
  localparam logic [2:0] legacy_zeros    = 3'h0;
  localparam logic [7:0] underrun_fill   = 8'h00;

  typedef enum logic [1:0] {
    phase_idle    = 2'h0,
    phase_command = 2'h1,
    phase_exec    = 2'h2,
    phase_result  = 2'h3
  } phase_type;

  typedef enum logic [1:0] {
    basic_compat_mode    = 2'h0,
    extended_compat_mode = 2'h1,
    legacy_model_mode    = 2'h2
  } reg_mode_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } io_req_type;

  typedef struct packed {
    phase_type    phase;
    logic         exec_read;
    logic         polled_mode;
    logic [3:0]   drive_seeking_flag;
    logic         cmd_end;
    logic         fifo_enable;
    logic [3:0]   threshold;
    logic         rate_select_wr;
    logic [1:0]   rate_select_in;
    logic         dma_enable_mirror;
    logic         soft_reset;
    reg_mode_type reg_mode;
  } engine_ctl_type;

  typedef struct packed {
    logic [1:0] rate;
    logic       no_precomp;
    logic       busy;
    logic       halted;
    logic       abort;
    logic       exec_seen;
    logic       dchg_meta;
    logic       dchg_sync;
    logic       service_due;
    logic [7:0] rdata;
    logic [7:0] rdata_oe_n;
  } front_state_type;

endpackage

// [floppy_host_model.sv]
// host bus model: register strobes and status polling around data port bytes
`timescale 1ns/1ns
`default_nettype none
module floppy_host_model (
  input  wire logic                       clk_sys,
  output var  floppy_regs_pkg::io_req_type io,
  input  wire logic [7:0]                 io_rdata,
  input  wire logic [7:0]                 io_rdata_oe_n
);
  initial io = '0;

  // released lines flip, so a stale value cannot pass for a real one
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] oe);
    @(posedge clk_sys);
    io.rd   <= 1'b1;
    io.addr <= a;
    @(posedge clk_sys);
    io.rd   <= 1'b0;
    io.addr <= ~a;
    #1;
    d  = io_rdata;
    oe = io_rdata_oe_n;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io.wr    <= 1'b1;
    io.addr  <= a;
    io.wdata <= d;
    @(posedge clk_sys);
    io.wr    <= 1'b0;
    io.addr  <= ~a;
    io.wdata <= ~d;
  endtask

  // polls status before every byte; gives up after a bounded wait
  task automatic data_xfer(input logic rd_dir, inout logic [7:0] d, output logic ok);
    logic [7:0] s;
    logic [7:0] oe;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(floppy_regs_pkg::main_status_addr, s, oe);
      ok = (s[7] === 1'b1) && (s[6] === rd_dir);
    end
    if (ok && rd_dir) rd(floppy_regs_pkg::command_data_port_addr, d, oe);
    else if (ok) wr(floppy_regs_pkg::command_data_port_addr, d);
  endtask
endmodule
`default_nettype wire

// [floppy_host_status_data_regs_tb_top.sv]
// self-checking bench for the floppy host register front end
`timescale 1ns/1ns
`default_nettype none
module floppy_host_status_data_regs_tb_top;
  logic                           clk_sys;
  logic                           nrst;
  logic                           ce;
  floppy_regs_pkg::io_req_type    io;
  floppy_regs_pkg::engine_ctl_type eng;
  logic [7:0]                     io_rdata;
  logic [7:0]                     io_rdata_oe_n;
  logic                           eng_byte_valid;
  logic [7:0]                     eng_byte_data;
  logic                           eng_byte_ready;
  logic                           to_eng_valid;
  logic [7:0]                     to_eng_data;
  logic                           eng_take;
  logic                           disk_change_pin;
  logic                           xfer_abort;
  logic                           zero_fill;
  logic                           service_due;
  logic [7:0]                     d;
  logic [7:0]                     oe;
  logic                           ok;
  int                             bad_count = 0;
  int                             compares = 0;

  floppy_host_status_data_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .io(io),
    .io_rdata(io_rdata), .io_rdata_oe_n(io_rdata_oe_n), .eng(eng),
    .eng_byte_valid(eng_byte_valid), .eng_byte_data(eng_byte_data),
    .eng_byte_ready(eng_byte_ready), .to_eng_valid(to_eng_valid), .to_eng_data(to_eng_data),
    .eng_take(eng_take), .disk_change_pin(disk_change_pin), .xfer_abort(xfer_abort),
    .zero_fill(zero_fill), .service_due(service_due));
  floppy_host_model host (.clk_sys(clk_sys), .io(io), .io_rdata(io_rdata),
    .io_rdata_oe_n(io_rdata_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic sts(input logic [7:0] e);
    host.rd(floppy_regs_pkg::main_status_addr, d, oe);
    check("status", d, e);
  endtask

  task automatic dir_chk(input logic [7:0] e, input logic [7:0] eoe);
    host.rd(floppy_regs_pkg::digital_input_addr, d, oe);
    check("dir", d, e);
    check("dir_oe_n", oe, eoe);
  endtask

  function automatic logic [7:0] dir_exp(input logic [1:0] m, input logic [1:0] r,
                                         input logic np, input logic dma, input logic dc);
    case (m)
      2'h1: return {~dc, 4'hf, r[1], r[0], (r == 2'h1 || r == 2'h2)};
      2'h2: return {~dc, 3'h0, dma, np, r};
      default: return {~dc, 7'h00};
    endcase
  endfunction

  initial begin
    #400000;
    bad_count++;
    test_done();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    eng = '0;
    eng_byte_valid = 1'b0;
    eng_byte_data = 8'h00;
    eng_take = 1'b0;
    disk_change_pin = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    sts(8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) eng.drive_seeking_flag <= 4'h1 << i;
      sts(8'h80 | (8'h01 << i));
    end
    @(posedge clk_sys) eng.drive_seeking_flag <= 4'h0;
    d = 8'h46;
    host.data_xfer(1'b0, d, ok);
    check("write_ok", {7'h00, ok}, 8'h01);
    sts(8'h10);
    host.wr(floppy_regs_pkg::command_data_port_addr, 8'h99);
    #1 check("to_eng", to_eng_data, 8'h46);
    @(posedge clk_sys) eng_take <= 1'b1;
    @(posedge clk_sys) eng_take <= 1'b0;
    sts(8'h90);
    @(posedge clk_sys) eng.cmd_end <= 1'b1;
    @(posedge clk_sys) eng.cmd_end <= 1'b0;
    sts(8'h80);
    // byte left over from the result phase must not reach the data phase
    @(posedge clk_sys) eng.phase <= floppy_regs_pkg::phase_result;
    eng_byte_valid <= 1'b1;
    eng_byte_data <= 8'h5a;
    @(posedge clk_sys) eng_byte_valid <= 1'b0;
    sts(8'hc0);
    @(posedge clk_sys) eng.phase <= floppy_regs_pkg::phase_exec;
    eng.exec_read <= 1'b1;
    eng.polled_mode <= 1'b1;
    sts(8'h60);
    // fill the fifo until refused, then one byte too many
    @(posedge clk_sys) eng.fifo_enable <= 1'b1;
    eng.threshold <= 4'h4;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys) eng_byte_valid <= 1'b1;
      eng_byte_data <= 8'h20 + 8'(i);
    end
    @(posedge clk_sys) eng_byte_data <= 8'hee;
    #1 check("ready_full", {7'h00, eng_byte_ready}, 8'h00);
    check("service_due", {7'h00, service_due}, 8'h01);
    @(posedge clk_sys) eng_byte_valid <= 1'b0;
    #1 check("overrun", {7'h00, xfer_abort}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      host.data_xfer(1'b1, d, ok);
      check("drain", d, 8'h20 + 8'(i));
    end
    sts(8'h60);
    check("service_idle", {7'h00, service_due}, 8'h00);
    // empty read side: no request, so the port answers 00 and pops nothing
    host.rd(floppy_regs_pkg::command_data_port_addr, d, oe);
    check("empty_read", d, 8'h00);
    check("empty_oe_n", oe, 8'h00);
    // underrun on a disk write
    @(posedge clk_sys) eng.cmd_end <= 1'b1;
    eng.exec_read <= 1'b0;
    eng.fifo_enable <= 1'b0;
    @(posedge clk_sys) eng.cmd_end <= 1'b0;
    eng_take <= 1'b1;
    @(posedge clk_sys) eng_take <= 1'b0;
    #1 check("underrun", {7'h00, xfer_abort}, 8'h01);
    check("zero_fill", {6'h00, zero_fill, to_eng_valid}, 8'h03);
    check("fill_byte", to_eng_data, 8'h00);
    sts(8'h20);
    @(posedge clk_sys) eng.cmd_end <= 1'b1;
    eng.phase <= floppy_regs_pkg::phase_idle;
    @(posedge clk_sys) eng.cmd_end <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys) eng.reg_mode <= floppy_regs_pkg::reg_mode_type'(m);
      dir_chk(dir_exp(2'(m), 2'h2, 1'b0, 1'b0, 1'b0), (m == 0) ? 8'h7f : 8'h00);
    end
    @(posedge clk_sys) eng.dma_enable_mirror <= 1'b1;
    host.wr(floppy_regs_pkg::digital_input_addr, 8'h05);
    dir_chk(dir_exp(2'h2, 2'h1, 1'b1, 1'b1, 1'b0), 8'h00);
    @(posedge clk_sys) eng.rate_select_wr <= 1'b1;
    eng.rate_select_in <= 2'h3;
    @(posedge clk_sys) eng.rate_select_wr <= 1'b0;
    dir_chk(dir_exp(2'h2, 2'h3, 1'b1, 1'b1, 1'b0), 8'h00);
    @(posedge clk_sys) eng.soft_reset <= 1'b1;
    disk_change_pin <= 1'b1;
    @(posedge clk_sys) eng.soft_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    dir_chk(dir_exp(2'h2, 2'h3, 1'b1, 1'b1, 1'b1), 8'h00);
    host.rd(3'h6, d, oe);
    check("unmapped_oe_n", oe, 8'hff);
    @(posedge clk_sys) nrst <= 1'b0;
    @(posedge clk_sys) nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    dir_chk(dir_exp(2'h2, 2'h2, 1'b0, 1'b1, 1'b1), 8'h00);
    @(posedge clk_sys) eng.reg_mode <= floppy_regs_pkg::extended_compat_mode;
    host.wr(floppy_regs_pkg::digital_input_addr, 8'h00);
    dir_chk(dir_exp(2'h1, 2'h0, 1'b0, 1'b1, 1'b1), 8'h00);
    // a frozen block must ignore a rate write
    @(posedge clk_sys) ce <= 1'b0;
    host.wr(floppy_regs_pkg::digital_input_addr, 8'h03);
    @(posedge clk_sys) ce <= 1'b1;
    dir_chk(dir_exp(2'h1, 2'h0, 1'b0, 1'b1, 1'b1), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
